//--- hdl/cirq_route_top.sv
// Interrupt routing core: masks, status view, two pulse outputs
`timescale 1ns/1ps
// Behaviour
// - Headset insertion drives secondary output only while its mask bit is set.
// - Button press drives secondary output only while its mask bit is set.
// - Playback range-control power event drives secondary output only when enabled.
// - Record gain-control noise event drives secondary output only when enabled.
// - Driver short-circuit event drives secondary output only when enabled.
// - Signal-engine interrupts drive secondary output only when enabled.
// - DC measurement data-ready drives secondary output only when enabled.
// - Single mode: one active-high pulse of two milliseconds per event.
// - Repeat mode: 2 ms pulses every 4 ms until flag reads done.
// - Pen touch or data-ready drives primary output only when enabled.
// - Status bit shows pen touch live, read only.
// - Status bit shows converted data ready, read only.
// - Status bit shows measurement outside threshold range, read only.
// - Sticky flags are read only, clear on read, set on new trigger.
module cirq_route_top
#(
  parameter int unsigned CNT_W      = cirq_pkg::CNT_W,
  parameter int unsigned PULSE_CYC  = cirq_pkg::PULSE_CYC,
  parameter int unsigned PERIOD_CYC = cirq_pkg::PERIOD_CYC
)
(
  // Clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Reads of the other flag registers
  input  wire logic       flag44_rd,
  input  wire logic       flag45_rd,
  // Event sources
  input  wire logic       evt_headset_ins,
  input  wire logic       evt_button,
  input  wire logic       evt_drc_power,
  input  wire logic       evt_agc_noise,
  input  wire logic       evt_driver_short,
  input  wire logic       evt_engine,
  input  wire logic       evt_dc_meas_ready,
  input  wire logic       sar_pen_touch,
  input  wire logic       sar_data_ready,
  input  wire logic       sar_out_of_range,
  // Primary output's other causes
  input  wire logic       primary_ext_trig,
  input  wire logic       primary_repeat_mode,
  // Interrupt outputs
  output logic            primary_irq_out,
  output logic            secondary_irq_out
);
  localparam int unsigned N = cirq_pkg::SRC_N;

  logic [7:0]   sec_mask_reg;
  logic [7:0]   sar_route_reg;
  logic [2:0]   seen_reg;
  logic [2:0]   seen_next;
  logic [7:0]   rdata_reg;
  logic [7:0]   rdata_next;
  logic [7:0]   sar_view;
  logic [N-1:0] src;
  logic [N-1:0] src_rise;
  logic [N-1:0] flags;
  logic [6:0]   sec_hits;
  logic         wr_sec;
  logic         wr_sar;
  logic         rd_any;
  logic         rd_sar;
  logic         rd_flag;
  logic         sec_trig;
  logic         pri_trig;

  cirq_pulse_if pri_if ();
  cirq_pulse_if sec_if ();

  // Decode
  assign wr_sec  = reg_wr && reg_addr == cirq_pkg::SEC_MASK_OFS;
  assign wr_sar  = reg_wr && reg_addr == cirq_pkg::SAR_ROUTE_OFS;
  assign rd_any  = ce && reg_rd;
  assign rd_sar  = rd_any && reg_addr == cirq_pkg::SAR_ROUTE_OFS;
  assign rd_flag = rd_any && (reg_addr == cirq_pkg::FLAG_LO_OFS || reg_addr == cirq_pkg::FLAG_HI_OFS);

  // Pen touch and data-ready share one routing enable
  assign src = {sar_out_of_range, sar_pen_touch | sar_data_ready, evt_headset_ins, evt_button,
                evt_drc_power, evt_agc_noise, evt_driver_short, evt_engine, evt_dc_meas_ready};

  assign sec_hits = src_rise[6:0] & sec_mask_reg[7:1];
  // OR of enabled sources, threshold enable
  assign sec_trig = (|sec_hits) | (src_rise[cirq_pkg::SRC_THR] & sar_route_reg[cirq_pkg::SAR_THR2_BIT]);
  assign pri_trig = (src_rise[cirq_pkg::SRC_PEN] & sar_route_reg[cirq_pkg::SAR_PEN1_BIT])
                  | (src_rise[cirq_pkg::SRC_THR] & sar_route_reg[cirq_pkg::SAR_THR1_BIT])
                  | primary_ext_trig;

  // repeat ends once 44, 45 and 50 read; a read beats a new trigger
  assign seen_next = (seen_reg & ~{3{sec_trig | pri_trig}}) | {flag44_rd, flag45_rd, rd_sar};

  assign sec_if.trig        = sec_trig;
  assign sec_if.repeat_mode = sec_mask_reg[cirq_pkg::SEC_REPEAT_BIT];
  assign sec_if.stop        = &seen_reg;
  assign pri_if.trig        = pri_trig;
  assign pri_if.repeat_mode = primary_repeat_mode;
  assign pri_if.stop        = &seen_reg;

  // live status, reserved bit reads zero
  assign sar_view = {sar_route_reg[7:4], sar_pen_touch, sar_data_ready, sar_out_of_range, 1'b0};

  // flags readable only, no write path
  assign rdata_next = (reg_addr == cirq_pkg::SEC_MASK_OFS)  ? sec_mask_reg :
                      (reg_addr == cirq_pkg::SAR_ROUTE_OFS) ? sar_view :
                      (reg_addr == cirq_pkg::FLAG_LO_OFS)   ? flags[7:0] :
                      (reg_addr == cirq_pkg::FLAG_HI_OFS)   ? {7'h00, flags[8]} : 8'h00;

  assign reg_rdata         = rdata_reg;
  assign primary_irq_out   = pri_if.pulse;
  assign secondary_irq_out = sec_if.pulse;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_mask_reg  <= cirq_pkg::SEC_MASK_RST;
      sar_route_reg <= cirq_pkg::SAR_ROUTE_RST;
      seen_reg      <= 3'h0;
      rdata_reg     <= 8'h00;
    end
    else if (ce)
    begin
      seen_reg <= seen_next;
      if (wr_sec)
        sec_mask_reg <= reg_wdata;
      if (wr_sar)
        sar_route_reg <= reg_wdata & cirq_pkg::SAR_WR_MASK;
      if (reg_rd)
        rdata_reg <= rdata_next;
    end
  end

  cirq_event_flags #(.N(N)) u_flags
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .src     (src),
    .clr     (rd_flag),
    .rise    (src_rise),
    .flags   (flags)
  );

  cirq_pulse_gen #(.CNT_W(CNT_W), .PULSE_CYC(PULSE_CYC), .PERIOD_CYC(PERIOD_CYC)) u_pri
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .pif     (pri_if)
  );

  cirq_pulse_gen #(.CNT_W(CNT_W), .PULSE_CYC(PULSE_CYC), .PERIOD_CYC(PERIOD_CYC)) u_sec
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .pif     (sec_if)
  );

  // Helper counters of high and low spans on the secondary output
  logic [CNT_W-1:0] hi_cnt;
  logic [CNT_W-1:0] lo_cnt;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_cnt <= '0;
      lo_cnt <= '0;
    end
    else if (ce)
    begin
      hi_cnt <= secondary_irq_out ? hi_cnt + CNT_W'(1) : '0;
      lo_cnt <= (!secondary_irq_out && !sec_if.idle) ? lo_cnt + CNT_W'(1) : '0;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_sec_gate(int b);
    (ce && sec_if.idle && src_rise == (9'h001 << b)) |=> (secondary_irq_out == sec_mask_reg[b + 1]);
  endproperty

  property p_sec_ins;
    p_sec_gate(6);
  endproperty
  a_sec_ins: assert property (p_sec_ins) else $error("insertion gating wrong");

  property p_sec_btn;
    p_sec_gate(5);
  endproperty
  a_sec_btn: assert property (p_sec_btn) else $error("button gating wrong");

  property p_sec_drc;
    p_sec_gate(4);
  endproperty
  a_sec_drc: assert property (p_sec_drc) else $error("range-control gating wrong");

  property p_sec_agc;
    p_sec_gate(3);
  endproperty
  a_sec_agc: assert property (p_sec_agc) else $error("gain-control gating wrong");

  property p_sec_short;
    p_sec_gate(2);
  endproperty
  a_sec_short: assert property (p_sec_short) else $error("short gating wrong");

  property p_sec_eng;
    p_sec_gate(1);
  endproperty
  a_sec_eng: assert property (p_sec_eng) else $error("engine gating wrong");

  property p_sec_dcm;
    p_sec_gate(0);
  endproperty
  a_sec_dcm: assert property (p_sec_dcm) else $error("dc measure gating wrong");

  property p_sec_width;
    $fell(secondary_irq_out) |-> hi_cnt == CNT_W'(PULSE_CYC);
  endproperty
  a_sec_width: assert property (p_sec_width) else $error("pulse width wrong");

  property p_sec_period;
    ($rose(secondary_irq_out) && !$past(sec_if.idle)) |-> lo_cnt == CNT_W'(PERIOD_CYC - PULSE_CYC);
  endproperty
  a_sec_period: assert property (p_sec_period) else $error("repeat gap wrong");

  property p_sec_stop;
    (ce && seen_reg == 3'h7 && !sec_if.idle && !secondary_irq_out) |=> sec_if.idle;
  endproperty
  a_sec_stop: assert property (p_sec_stop) else $error("repeat did not stop");

  property p_pri_pen;
    (ce && pri_if.idle && src_rise == 9'h080 && !primary_ext_trig)
      |=> primary_irq_out == sar_route_reg[cirq_pkg::SAR_PEN1_BIT];
  endproperty
  a_pri_pen: assert property (p_pri_pen) else $error("pen routing wrong");

  property p_thr_both;
    (ce && pri_if.idle && sec_if.idle && src_rise == 9'h100 && !primary_ext_trig)
      |=> (primary_irq_out == sar_route_reg[cirq_pkg::SAR_THR1_BIT])
       && (secondary_irq_out == sar_route_reg[cirq_pkg::SAR_THR2_BIT]);
  endproperty
  a_thr_both: assert property (p_thr_both) else $error("threshold routing wrong");

  property p_status;
    rd_sar |=> reg_rdata[3:0] == {$past(sar_pen_touch), $past(sar_data_ready), $past(sar_out_of_range), 1'b0};
  endproperty
  a_status: assert property (p_status) else $error("status view wrong");

  property p_flag_clr;
    (rd_flag && src_rise == 9'h000) |=> flags == 9'h000;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared on read");

  property p_pri_ext;
    (ce && pri_if.idle && primary_ext_trig) |=> primary_irq_out;
  endproperty
  a_pri_ext: assert property (p_pri_ext) else $error("ored cause lost");

  property p_sec_single;
    ($fell(secondary_irq_out) && !$past(sec_mask_reg[cirq_pkg::SEC_REPEAT_BIT])) |-> sec_if.idle;
  endproperty
  a_sec_single: assert property (p_sec_single) else $error("single pulse repeated");

  property p_seen_trig;
    (ce && (sec_trig || pri_trig) && !flag44_rd && !flag45_rd && !rd_sar) |=> seen_reg == 3'h0;
  endproperty
  a_seen_trig: assert property (p_seen_trig) else $error("read set not restarted");

  property p_mask_wr;
    (ce && wr_sec) |=> sec_mask_reg == $past(reg_wdata);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  property p_route_wr;
    (ce && wr_sar) |=> sar_route_reg == ($past(reg_wdata) & cirq_pkg::SAR_WR_MASK);
  endproperty
  a_route_wr: assert property (p_route_wr) else $error("status bits writable");

  // Set beats a clear in the same cycle
  property p_flag_set;
    (ce && src_rise != 9'h000) |=> (flags & $past(src_rise)) == $past(src_rise);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_flag_hold;
    (ce && src_rise == 9'h000 && !rd_flag) |=> flags == $past(flags);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag changed without cause");

  c_sec_repeat: cover property ($rose(secondary_irq_out) && !$past(sec_if.idle));
  c_sec_stop: cover property (ce && sec_if.stop && !sec_if.idle ##1 sec_if.idle);
  c_thr_both: cover property ($rose(primary_irq_out) && $rose(secondary_irq_out));
  c_pri_ext: cover property (ce && pri_if.idle && primary_ext_trig);
endmodule // cirq_route_top

//--- include/cirq_pkg.sv
// Constants and types for the codec interrupt routing block
package cirq_pkg;
  // Timing
  localparam int unsigned CLK_KHZ    = 40000;
  localparam int unsigned PULSE_US   = 2000;
  localparam int unsigned PERIOD_US  = 4000;
  localparam int unsigned PULSE_CYC  = (PULSE_US * CLK_KHZ) / 1000;
  localparam int unsigned PERIOD_CYC = (PERIOD_US * CLK_KHZ) / 1000;
  localparam int unsigned CNT_W      = 18;
  // Register offsets
  localparam logic [7:0] SEC_MASK_OFS  = 8'h31;
  localparam logic [7:0] SAR_ROUTE_OFS = 8'h32;
  localparam logic [7:0] FLAG_LO_OFS   = 8'h7E;
  localparam logic [7:0] FLAG_HI_OFS   = 8'h7F;
  // Reset values and write masks
  localparam logic [7:0] SEC_MASK_RST  = 8'h00;
  localparam logic [7:0] SAR_ROUTE_RST = 8'h00;
  localparam logic [7:0] SAR_WR_MASK   = 8'hF0;
  // Field positions
  localparam int unsigned SEC_REPEAT_BIT = 0;
  localparam int unsigned SAR_THR1_BIT   = 7;
  localparam int unsigned SAR_PEN1_BIT   = 6;
  localparam int unsigned SAR_THR2_BIT   = 5;
  // Event vector layout
  localparam int unsigned SRC_N   = 9;
  localparam int unsigned SRC_PEN = 7;
  localparam int unsigned SRC_THR = 8;
  typedef enum logic [2:0]
  {
    CIRQ_IDLE = 3'b001,
    CIRQ_HIGH = 3'b010,
    CIRQ_LOW  = 3'b100
  } cirq_state_t;
endpackage

//--- include/cirq_pulse_if.sv
// Carrier between the routing core and one pulse generator
`timescale 1ns/1ps
interface cirq_pulse_if;
  logic trig;
  logic repeat_mode;
  logic stop;
  logic pulse;
  logic idle;
  modport gen (input trig, input repeat_mode, input stop, output pulse, output idle);
  modport ctl (output trig, output repeat_mode, output stop, input pulse, input idle);
endinterface

//--- hdl/cirq_event_flags.sv
// Edge detection and sticky flags for the interrupt sources
`timescale 1ns/1ps
module cirq_event_flags
#(
  parameter int unsigned N = cirq_pkg::SRC_N
)
(
  // Clock and control
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Sources and clear
  input  wire logic [N-1:0] src,
  input  wire logic         clr,
  // Results
  output logic      [N-1:0] rise,
  output logic      [N-1:0] flags
);
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      logic src_d_reg;
      logic flag_reg;
      assign rise[i]  = src[i] & ~src_d_reg;
      assign flags[i] = flag_reg;
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          src_d_reg <= 1'b0;
          flag_reg  <= 1'b0;
        end
        else if (ce)
        begin
          src_d_reg <= src[i];
          flag_reg  <= rise[i] | (flag_reg & ~clr);
        end
      end
    end
  endgenerate
endmodule // cirq_event_flags

//--- hdl/cirq_pulse_gen.sv
// Single or repeating interrupt pulse generator
`timescale 1ns/1ps
module cirq_pulse_gen
#(
  parameter int unsigned CNT_W      = cirq_pkg::CNT_W,
  parameter int unsigned PULSE_CYC  = cirq_pkg::PULSE_CYC,
  parameter int unsigned PERIOD_CYC = cirq_pkg::PERIOD_CYC
)
(
  // Clock and control
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  input  wire logic   ce,
  // Trigger and pulse
  cirq_pulse_if.gen   pif
);
  cirq_pkg::cirq_state_t state_reg;
  cirq_pkg::cirq_state_t state_next;
  logic [CNT_W-1:0]      cnt_reg;
  logic [CNT_W-1:0]      cnt_next;
  logic [CNT_W-1:0]      cnt_inc;
  logic                  pulse_reg;
  logic                  hi_end;
  logic                  per_end;

  assign cnt_inc  = cnt_reg + CNT_W'(1);
  assign hi_end   = cnt_reg == CNT_W'(PULSE_CYC - 1);
  assign per_end  = cnt_reg == CNT_W'(PERIOD_CYC - 1);
  assign pif.pulse = pulse_reg;
  assign pif.idle  = state_reg == cirq_pkg::CIRQ_IDLE;

  // Events during a pulse merge into it
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_inc;
    case (state_reg)
      cirq_pkg::CIRQ_IDLE:
      begin
        cnt_next = '0;
        if (pif.trig)
          state_next = cirq_pkg::CIRQ_HIGH;
      end
      cirq_pkg::CIRQ_HIGH:
      begin
        if (hi_end)
          state_next = (pif.repeat_mode && !pif.stop) ? cirq_pkg::CIRQ_LOW : cirq_pkg::CIRQ_IDLE;
      end
      cirq_pkg::CIRQ_LOW:
      begin
        if (pif.stop)
          state_next = cirq_pkg::CIRQ_IDLE;
        else if (per_end)
        begin
          state_next = cirq_pkg::CIRQ_HIGH;
          cnt_next   = '0;
        end
      end
      default:
      begin
        state_next = cirq_pkg::CIRQ_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= cirq_pkg::CIRQ_IDLE;
      cnt_reg   <= '0;
      pulse_reg <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pulse_reg <= state_next == cirq_pkg::CIRQ_HIGH;
    end
  end
endmodule // cirq_pulse_gen

//--- tb/cirq_host_model.sv
// Host side: counts interrupt pulses and performs flag register reads
`timescale 1ns/1ps
module cirq_host_model
(
  // Clock
  input  wire logic sys_clk,
  // Interrupt lines from the device
  input  wire logic primary_irq_out,
  input  wire logic secondary_irq_out,
  // Reads of the external flag registers
  output logic      flag44_rd,
  output logic      flag45_rd
);
  logic p1;
  logic p2;
  int   cnt1;
  int   cnt2;
  int   w2;
  int   last_w2;

  initial
  begin
    flag44_rd = 1'b0;
    flag45_rd = 1'b0;
    p1 = 1'b0;
    p2 = 1'b0;
    cnt1 = 0;
    cnt2 = 0;
    w2 = 0;
    last_w2 = 0;
  end

  // Counts rising edges; width kept for the last secondary pulse
  always @(posedge sys_clk)
  begin
    if (primary_irq_out === 1'b1 && p1 !== 1'b1)
      cnt1 <= cnt1 + 1;
    if (secondary_irq_out === 1'b1 && p2 !== 1'b1)
      cnt2 <= cnt2 + 1;
    if (secondary_irq_out === 1'b1)
      w2 <= w2 + 1;
    else if (w2 != 0)
    begin
      last_w2 <= w2;
      w2 <= 0;
    end
    p1 <= primary_irq_out;
    p2 <= secondary_irq_out;
  end

  // host reads flags
  // Reads of registers 44 and 45, one cycle each; 50 is read by the bench
  task automatic read_flags;
    @(posedge sys_clk);
    flag44_rd <= 1'b1;
    @(posedge sys_clk);
    flag44_rd <= 1'b0;
    flag45_rd <= 1'b1;
    @(posedge sys_clk);
    flag45_rd <= 1'b0;
  endtask
endmodule // cirq_host_model

//--- tb/cirq_route_top_bench.sv
// Self-checking bench for the interrupt routing core
`timescale 1ns/1ps
module cirq_route_top_bench;
  // Short pulse timing for simulation
  localparam int unsigned PC = 4;
  localparam int unsigned PP = 10;
  logic       sys_clk;
  logic       rst_n;
  logic       ce;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  wire logic  f44;
  wire logic  f45;
  logic [6:0] ev;
  logic       pen;
  logic       dav;
  logic       oor;
  logic       ext_trig;
  logic       ext_rep;
  logic       irq1;
  logic       irq2;
  logic [7:0] d;
  int         c1;
  int         c2;
  int         miscompares;
  int         cmp_count;

  cirq_route_top #(.PULSE_CYC(PC), .PERIOD_CYC(PP)) i_cirq_route_top
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flag44_rd(f44), .flag45_rd(f45),
    .evt_headset_ins(ev[6]), .evt_button(ev[5]), .evt_drc_power(ev[4]), .evt_agc_noise(ev[3]),
    .evt_driver_short(ev[2]), .evt_engine(ev[1]), .evt_dc_meas_ready(ev[0]),
    .sar_pen_touch(pen), .sar_data_ready(dav), .sar_out_of_range(oor),
    .primary_ext_trig(ext_trig), .primary_repeat_mode(ext_rep),
    .primary_irq_out(irq1), .secondary_irq_out(irq2)
  );

  cirq_host_model i_cirq_host_model
  (
    .sys_clk(sys_clk), .primary_irq_out(irq1), .secondary_irq_out(irq2), .flag44_rd(f44), .flag45_rd(f45)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    v = reg_rdata;
  endtask

  // One rising edge on event i, then wait out the pulse
  task automatic fire(input int i, input int e2);
    c2 = i_cirq_host_model.cnt2;
    @(posedge sys_clk);
    ev[i] <= 1'b1;
    tick(2);
    ev[i] <= 1'b0;
    tick(PP + 2);
    check("secondary pulses", 8'(i_cirq_host_model.cnt2 - c2), 8'(e2));
  endtask

  task automatic t_masks;
    logic [7:0] m;
    for (int i = 0; i < 7; i++)
    begin
      m = 8'h02 << i;
      wr(8'h31, m);
      rd(8'h31, d);
      check("mask readback", d, m);
      fire(i, 1);
      check("pulse width", 8'(i_cirq_host_model.last_w2), 8'(PC));
      wr(8'h31, 8'hFE ^ m);
      fire(i, 0);
    end
    wr(8'h31, 8'h00);
  endtask

  task automatic t_status;
    // reserved low bit written as zero
    wr(8'h32, 8'hFE);
    rd(8'h32, d);
    check("routing readback", d, 8'hF0);
    pen <= 1'b1;
    oor <= 1'b1;
    tick(PP + 2);
    rd(8'h32, d);
    check("status pen oor", d, 8'hFA);
    pen <= 1'b0;
    oor <= 1'b0;
    dav <= 1'b1;
    tick(PP + 2);
    rd(8'h32, d);
    check("status data ready", d, 8'hF4);
    dav <= 1'b0;
    wr(8'h32, 8'h00);
  endtask

  // Routing of the shared converter events
  task automatic route(input logic [7:0] v, input bit thr, input int e1, input int e2);
    wr(8'h32, v);
    c1 = i_cirq_host_model.cnt1;
    c2 = i_cirq_host_model.cnt2;
    if (thr)
      oor <= 1'b1;
    else
      pen <= 1'b1;
    tick(2);
    oor <= 1'b0;
    pen <= 1'b0;
    tick(PP + 2);
    check("primary pulses", 8'(i_cirq_host_model.cnt1 - c1), 8'(e1));
    check("secondary pulses", 8'(i_cirq_host_model.cnt2 - c2), 8'(e2));
  endtask

  task automatic t_repeat;
    wr(8'h31, 8'h81);
    c2 = i_cirq_host_model.cnt2;
    @(posedge sys_clk);
    ev[6] <= 1'b1;
    tick(2);
    ev[6] <= 1'b0;
    // Reads complete inside a low phase
    tick(29);
    check("repeat pulses", 8'(i_cirq_host_model.cnt2 - c2), 8'h03);
    check("repeat width", 8'(i_cirq_host_model.last_w2), 8'(PC));
    i_cirq_host_model.read_flags();
    rd(8'h32, d);
    check("status idle", d, 8'h00);
    tick(PP);
    c2 = i_cirq_host_model.cnt2;
    tick(4 * PP);
    check("pulses after reads", 8'(i_cirq_host_model.cnt2 - c2), 8'h00);
    wr(8'h31, 8'h00);
  endtask

  task automatic t_sticky;
    rd(8'h7E, d);
    fire(3, 0);
    wr(8'h7E, 8'hFF);
    rd(8'h7E, d);
    check("sticky set", d, 8'h08);
    rd(8'h7E, d);
    check("sticky cleared", d, 8'h00);
    oor <= 1'b1;
    tick(2);
    oor <= 1'b0;
    rd(8'h7F, d);
    check("sticky threshold", d, 8'h01);
  endtask

  // Outside cause, held frozen for a while by a low clock enable
  task automatic t_ext;
    c1 = i_cirq_host_model.cnt1;
    ext_trig <= 1'b1;
    tick(1);
    ext_trig <= 1'b0;
    ce <= 1'b0;
    tick(PP);
    check("frozen primary", 8'(irq1), 8'h01);
    ce <= 1'b1;
    tick(PP + 2);
    check("outside cause pulses", 8'(i_cirq_host_model.cnt1 - c1), 8'h01);
    check("primary after pulse", 8'(irq1), 8'h00);
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    miscompares = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ev = 7'h00;
    pen = 1'b0;
    dav = 1'b0;
    oor = 1'b0;
    ext_trig = 1'b0;
    ext_rep = 1'b0;
    tick(10);
    rst_n <= 1'b1;
    tick(2);
    rd(8'h31, d);
    check("mask reset", d, cirq_pkg::SEC_MASK_RST);
    rd(8'h32, d);
    check("routing reset", d, cirq_pkg::SAR_ROUTE_RST);
    rd(8'h55, d);
    check("unmapped read", d, 8'h00);
    t_masks();
    t_status();
    route(8'h40, 1'b0, 1, 0);
    route(8'h80, 1'b1, 1, 0);
    route(8'h20, 1'b1, 0, 1);
    route(8'hA0, 1'b1, 1, 1);
    route(8'h00, 1'b1, 0, 0);
    t_repeat();
    t_sticky();
    t_ext();
    report_and_stop();
  end
endmodule // cirq_route_top_bench
